// ### hdl/cbd_clkbuz.sv
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
module cbd_clkbuz (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [21:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic clkbuz_out_pin_0,
  output logic clkbuz_out_pin_1
);

  typedef struct packed {
    logic [1:0][7:0] sel;
    logic [1:0] run;
    logic [1:0] pin;
    logic [cbd_pkg::PRE_W-1:0] pre;
    logic ack;
    logic [31:0] rdat;
  } cbd_state_t;

  cbd_state_t st_r;
  cbd_state_t st_nxt;

  // Ratio exponent for a divider code
  function automatic logic [3:0] cbd_div_exp(input logic [2:0] code);
    logic [3:0] e;
    e = cbd_pkg::DIV_EXP0;
    unique case (code)
      3'h0: e = cbd_pkg::DIV_EXP0;
      3'h1: e = cbd_pkg::DIV_EXP1;
      3'h2: e = cbd_pkg::DIV_EXP2;
      3'h3: e = cbd_pkg::DIV_EXP3;
      3'h4: e = cbd_pkg::DIV_EXP4;
      3'h5: e = cbd_pkg::DIV_EXP5;
      3'h6: e = cbd_pkg::DIV_EXP6;
      3'h7: e = cbd_pkg::DIV_EXP7;
    endcase
    return e;
  endfunction

  // Half-period boundary: low exp-1 prescaler bits all ones
  function automatic logic cbd_tick(input logic [2:0] code,
                                    input logic [cbd_pkg::PRE_W-1:0] pre);
    logic [3:0] e;
    logic [cbd_pkg::PRE_W-1:0] m;
    e = cbd_div_exp(code);
    m = '0;
    if (e > 4'h1) begin
      m = cbd_pkg::PRE_W'((14'h0001 << (e - 4'h1)) - 14'h0001);
    end
    return (pre & m) == m;
  endfunction

  // Byte-lane merge of a select register write; only lane 0 carries data
  function automatic logic [7:0] cbd_wr_sel(input logic [7:0] old,
                                            input logic [31:0] d,
                                            input logic lane);
    logic [7:0] v;
    v = old;
    if (lane) begin
      v = d[7:0] & cbd_pkg::SEL_MASK;
    end
    return v;
  endfunction

  // Select register after a single-bit write
  function automatic logic [7:0] cbd_bit_wr(input logic [7:0] old,
                                            input logic [2:0] pos,
                                            input logic val);
    logic [7:0] bmask;
    logic [7:0] v;
    bmask = 8'h01 << pos;
    v = old;
    if (val) begin
      v = old | bmask;
    end else begin
      v = old & ~bmask;
    end
    return v & cbd_pkg::SEL_MASK;
  endfunction

  // A channel runs only with enable set and the reserved source bit clear
  function automatic logic cbd_may_run(input logic [7:0] sel);
    logic ok;
    ok = sel[cbd_pkg::OE_POS] & ~sel[cbd_pkg::SRC_POS];
    return ok;
  endfunction

  // Read word for a register index; unmapped and write-only read zero
  function automatic logic [31:0] cbd_rd_word(input logic [19:0] a,
                                              input logic [1:0][7:0] sel,
                                              input logic [1:0] run,
                                              input logic [1:0] pin);
    logic [31:0] w;
    w = '0;
    unique case (a)
      cbd_pkg::SEL0_IDX: begin
        w[7:0] = sel[0];
      end
      cbd_pkg::SEL1_IDX: begin
        w[7:0] = sel[1];
      end
      cbd_pkg::STATUS_IDX: begin
        w[cbd_pkg::ST_RUN_LSB +: 2] = run;
        w[cbd_pkg::ST_PIN_LSB +: 2] = pin;
      end
      default: begin
        w = '0;
      end
    endcase
    return w;
  endfunction

  // One channel's next run flag and pin level, returned as {run, pin}.
  // Outputs come from flip-flops, so code 0 cannot reach the full clock
  // rate: it gives half of ref_clk, the same as code 1.
  function automatic logic [1:0] cbd_chan_step(input logic [7:0] sel,
                                               input logic run,
                                               input logic pin,
                                               input logic tick);
    logic run_n;
    logic pin_n;
    run_n = run;
    pin_n = pin;
    if (tick) begin
      if (!pin) begin
        // Enable is sampled only where a low phase ends, so no runt pulse
        run_n = cbd_may_run(sel);
        pin_n = run_n;
      end else begin
        // A high phase always completes before stopping
        pin_n = 1'b0;
      end
    end
    return {run_n, pin_n};
  endfunction

  // Select pair after a register write; unmapped writes change nothing
  function automatic logic [1:0][7:0] cbd_wr_apply(
      input logic [19:0] a,
      input logic [1:0][7:0] sel,
      input logic [31:0] d,
      input logic [2:0] pos,
      input logic ch,
      input logic val);
    logic [1:0][7:0] s;
    s = sel;
    unique case (a)
      cbd_pkg::SEL0_IDX: begin
        s[0] = cbd_wr_sel(sel[0], d, 1'b1);
      end
      cbd_pkg::SEL1_IDX: begin
        s[1] = cbd_wr_sel(sel[1], d, 1'b1);
      end
      cbd_pkg::BITOP_IDX: begin
        // Single-bit write: only the addressed bit moves
        s[ch] = cbd_bit_wr(sel[ch], pos, val);
      end
      default: begin
        s = sel;
      end
    endcase
    return s;
  endfunction

  logic req;
  logic wr_req;
  logic rd_req;
  logic [19:0] idx;
  logic [2:0] bop_bit;
  logic bop_ch;
  logic bop_val;

  // Ack blocks a new take for one cycle, so one request gives one pulse
  assign req = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign wr_req = req & wb_we_i & wb_sel_i[0];
  assign rd_req = req & ~wb_we_i;
  assign idx = wb_adr_i[21:2];
  assign bop_bit = wb_dat_i[cbd_pkg::BOP_IDX_LSB +: 3];
  assign bop_ch = wb_dat_i[cbd_pkg::BOP_CH_POS];
  assign bop_val = wb_dat_i[cbd_pkg::BOP_VAL_POS];

  always_comb begin
    logic tick0;
    logic tick1;
    logic [1:0] step0;
    logic [1:0] step1;
    tick0 = 1'b0;
    tick1 = 1'b0;
    step0 = '0;
    step1 = '0;
    st_nxt = st_r;
    st_nxt.ack = req;
    st_nxt.pre = st_r.pre + 1'b1;

    if (wr_req) begin
      st_nxt.sel = cbd_wr_apply(idx, st_r.sel, wb_dat_i, bop_bit, bop_ch,
                                bop_val);
    end

    // Read data stands only in the ack cycle, zero otherwise
    st_nxt.rdat = '0;
    if (rd_req) begin
      st_nxt.rdat = cbd_rd_word(idx, st_r.sel, st_r.run, st_r.pin);
    end

    // Both channels share the free prescaler, so their edges stay aligned
    tick0 = cbd_tick(st_r.sel[0][cbd_pkg::DIV_LSB +: cbd_pkg::DIV_W],
                     st_r.pre);
    step0 = cbd_chan_step(st_r.sel[0], st_r.run[0], st_r.pin[0], tick0);
    st_nxt.run[0] = step0[1];
    st_nxt.pin[0] = step0[0];

    tick1 = cbd_tick(st_r.sel[1][cbd_pkg::DIV_LSB +: cbd_pkg::DIV_W],
                     st_r.pre);
    step1 = cbd_chan_step(st_r.sel[1], st_r.run[1], st_r.pin[1], tick1);
    st_nxt.run[1] = step1[1];
    st_nxt.pin[1] = step1[0];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.sel <= {cbd_pkg::SEL_RESET, cbd_pkg::SEL_RESET};
      st_r.run <= 2'b00;
      st_r.pin <= 2'b00;
      st_r.pre <= cbd_pkg::PRE_RESET;
      st_r.ack <= 1'b0;
      st_r.rdat <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.rdat;
  assign wb_ack_o = st_r.ack;
  assign clkbuz_out_pin_0 = st_r.pin[0];
  assign clkbuz_out_pin_1 = st_r.pin[1];

endmodule

// ### hdl/cbd_pkg.sv
package cbd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [19:0] SEL0_IDX = 20'hfffa5;
  localparam logic [19:0] SEL1_IDX = 20'hfffa6;
  localparam logic [19:0] BITOP_IDX = 20'hfffa8;
  localparam logic [19:0] STATUS_IDX = 20'hfffa9;

  // Select register fields
  localparam int OE_POS = 7;
  localparam int SRC_POS = 3;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 3;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] SEL_MASK = 8'h8f;

  // Bit-write register fields
  localparam int BOP_CH_POS = 0;
  localparam int BOP_IDX_LSB = 1;
  localparam int BOP_VAL_POS = 4;

  // Status register fields
  localparam int ST_RUN_LSB = 0;
  localparam int ST_PIN_LSB = 2;

  // Prescaler width covers the largest ratio, 2^13
  localparam int PRE_W = 13;
  localparam logic [PRE_W-1:0] PRE_RESET = 13'h0000;

  // Exponent of the divide ratio for each divider code
  localparam logic [3:0] DIV_EXP0 = 4'h0;
  localparam logic [3:0] DIV_EXP1 = 4'h1;
  localparam logic [3:0] DIV_EXP2 = 4'h2;
  localparam logic [3:0] DIV_EXP3 = 4'h3;
  localparam logic [3:0] DIV_EXP4 = 4'h4;
  localparam logic [3:0] DIV_EXP5 = 4'hb;
  localparam logic [3:0] DIV_EXP6 = 4'hc;
  localparam logic [3:0] DIV_EXP7 = 4'hd;

endpackage

// ### tb/cbd_buzz_model.sv
`timescale 1ns/1ps
module cbd_buzz_model (
  input wire logic ref_clk,
  input wire logic pin,
  output int period,
  output int high_len,
  output int rises
);
  int cnt = 0;
  int hi = 0;
  logic last = 1'b0;
  int rs = 0;
  assign rises = rs;
  // Listener only: pin direction and latch taken as 0
  // Fast codes exceed 16 MHz only to test the divider
  always @(posedge ref_clk) begin
    last <= pin;
    cnt <= cnt + 1;
    if (pin) hi <= hi + 1;
    if (pin && !last) begin
      period <= cnt;
      cnt <= 1;
      rs <= rs + 1;
    end
    if (!pin && last) begin
      high_len <= hi;
      hi <= 0;
    end
  end
endmodule

// ### tb/cbd_clkbuz_chk.sv
`timescale 1ns/1ps
module cbd_clkbuz_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic clkbuz_out_pin_0,
  input wire logic clkbuz_out_pin_1
);
  logic wrote_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) wrote_r <= 1'b0;
    else if (wb_ack_o && wb_we_i) wrote_r <= 1'b1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack missing");
  a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("stray ack");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  a_dat_mask: assert property (wb_ack_o |-> !(wb_dat_o & 32'hffffff70))
    else $error("reserved bits set");
  a_first_edge: assert property ($rose(rst_n) |->
    !clkbuz_out_pin_0 && !clkbuz_out_pin_1) else $error("pin after reset");
  a_quiet_pin0: assert property (!wrote_r |-> !clkbuz_out_pin_0)
    else $error("pin 0 runs unset");
  a_quiet_pin1: assert property (!wrote_r |-> !clkbuz_out_pin_1)
    else $error("pin 1 runs unset");
endmodule
bind cbd_clkbuz cbd_clkbuz_chk cbd_clkbuz_chk_inst (.*);

// ### tb/clock_buzzer_output_divider_test.sv
`timescale 1ns/1ps
module clock_buzzer_output_divider_test;
  localparam logic [21:0] A0 = {cbd_pkg::SEL0_IDX, 2'b00};
  localparam logic [21:0] A1 = {cbd_pkg::SEL1_IDX, 2'b00};
  localparam logic [21:0] AB = {cbd_pkg::BITOP_IDX, 2'b00};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [21:0] adr = 22'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd, q;
  logic ack;
  logic [1:0] pin;
  int per_m [2];
  int hi_m [2];
  int rs_m [2];
  int n_mismatch = 0;
  int samples_checked = 0;
  int ch, per, t;
  logic [2:0] c;
  // Divider code beside the expected period in cycles
  logic [19:0] rows [8] = '{20'h00002, 20'h10002, 20'h20004, 20'h30008,
    20'h40010, 20'h50800, 20'h61000, 20'h72000};
  always #2 ref_clk = ~ref_clk;
  cbd_clkbuz cbd_clkbuz_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .clkbuz_out_pin_0(pin[0]), .clkbuz_out_pin_1(pin[1]));
  for (genvar i = 0; i < 2; i++) begin : g_mod
    cbd_buzz_model cbd_buzz_model_inst (.ref_clk(ref_clk), .pin(pin[i]),
      .period(per_m[i]), .high_len(hi_m[i]), .rises(rs_m[i]));
  end
  task automatic wb(input logic w, input logic [21:0] a, input logic [31:0] d);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge ref_clk);
    while (ack !== 1'b1) @(posedge ref_clk);
    q = rd;
    req <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      ch = i % 2;
      c = rows[i][18:16];
      per = rows[i][15:0];
      wb(1'b1, ch ? A1 : A0, {29'h0, c});
      wb(1'b1, ch ? A1 : A0, {24'h0, 5'h10, c});
      t = rs_m[ch] + 3;
      for (int k = 0; k < 5 * per + 20 && rs_m[ch] < t; k++)
        @(posedge ref_clk);
      chk(rs_m[ch] >= t, 1'b1);
      chk(per_m[ch], per);
      chk(hi_m[ch], per / 2);
      wb(1'b1, ch ? A1 : A0, {29'h0, c});
      repeat (per + 4) @(posedge ref_clk);
      chk(pin, 2'b00);
    end
    wb(1'b1, A0, 32'h8f);
    rst_n <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    wb(1'b0, A0, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, A1, 32'hf8);
    wb(1'b0, A1, 32'h0);
    chk(q, 32'h88);
    repeat (8) @(posedge ref_clk);
    chk(pin, 2'b00);
    wb(1'b1, AB, 32'h1e);
    wb(1'b0, A0, 32'h0);
    chk(q, 32'h80);
    wb(1'b0, 22'h10, 32'h0);
    chk(q, 32'h0);
    give_verdict;
  end
endmodule
